// ---- src/scgb_sleep_gate.sv ----
// sleep clock gating register bank with apb slave and unit clock gates
`include "scgb_regs.svh"
module scgb_sleep_gate
    import scgb_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // apb slave
    input wire scgb_apb_req_type apb_req,
    output scgb_apb_rsp_type apb_rsp,
    // power mode from the power controller
    input wire scgb_mode_type pwr_mode,
    // peripheral access watch
    input wire scgb_periph_req_type periph_req,
    output logic periph_fault,
    // gated unit clocks: 0 async0, 1 async1, 2 sync0, 3 twowire0, 4 gptm0,
    // 5 gptm1
    output logic [`SCGB_NUM_UNITS-1:0] unit_clk,
    output logic [`SCGB_NUM_UNITS-1:0] unit_clk_en,
    // interrupt
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    // gating registers
    logic [31:0] sleep_gate_ff;
    logic [31:0] nxt_sleep_gate;
    logic [31:0] run_gate_ff;
    logic [31:0] nxt_run_gate;
    logic [31:0] deep_gate_ff;
    logic [31:0] nxt_deep_gate;
    logic [31:0] run_cfg_ff;
    logic [31:0] nxt_run_cfg;

    // interrupt state
    logic [31:0] int_stat_ff;
    logic [31:0] nxt_int_stat;
    logic [31:0] int_en_ff;
    logic [31:0] nxt_int_en;

    // bus response state
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pslverr_ff;
    logic nxt_pslverr;

    // unit enable and fault state
    logic fault_ff;
    logic nxt_fault;
    logic [`SCGB_NUM_UNITS-1:0] en_ff;
    logic [`SCGB_NUM_UNITS-1:0] nxt_en;
    logic [`SCGB_NUM_UNITS-1:0] sel_en;

    // bus decode
    logic setup;
    logic access;
    logic known;
    logic wr_acc;
    logic rd_acc;
    logic wr_sleep;
    logic wr_run;
    logic wr_deep;
    logic wr_cfg;
    logic wr_int_en;
    logic [31:0] rd_val;

    function automatic logic [`SCGB_NUM_UNITS-1:0] units_of(
        input logic [31:0] r);
        units_of = {r[`SCGB_BIT_GPTM1], r[`SCGB_BIT_GPTM0],
            r[`SCGB_BIT_TWOWIRE0], r[`SCGB_BIT_SSER0],
            r[`SCGB_BIT_ASER1], r[`SCGB_BIT_ASER0]};
    endfunction

    function automatic logic ofs_known(input logic [11:0] a);
        ofs_known = (a == `SCGB_SLEEP_GATE_OFS) || (a == `SCGB_RUN_GATE_OFS)
            || (a == `SCGB_DEEP_GATE_OFS) || (a == `SCGB_RUN_CFG_OFS)
            || (a == `SCGB_INT_STAT_OFS) || (a == `SCGB_INT_EN_OFS)
            || (a == `SCGB_INT_CLR_OFS);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, setup cycle latches read data
    assign setup = apb_req.psel & ~apb_req.penable;
    assign known = ofs_known(apb_req.paddr);
    assign access = apb_req.psel & apb_req.penable;
    // writes land at the access edge, where pready is sampled
    assign wr_acc = access & apb_req.pwrite & known;
    assign rd_acc = setup & ~apb_req.pwrite;
    assign wr_sleep = wr_acc && apb_req.paddr == `SCGB_SLEEP_GATE_OFS;
    assign wr_run = wr_acc && apb_req.paddr == `SCGB_RUN_GATE_OFS;
    assign wr_deep = wr_acc && apb_req.paddr == `SCGB_DEEP_GATE_OFS;
    assign wr_cfg = wr_acc && apb_req.paddr == `SCGB_RUN_CFG_OFS;
    assign wr_int_en = wr_acc && apb_req.paddr == `SCGB_INT_EN_OFS;

    always_comb begin
        rd_val = 32'h0000_0000;
        case (apb_req.paddr)
            `SCGB_SLEEP_GATE_OFS: rd_val = sleep_gate_ff;
            `SCGB_RUN_GATE_OFS: rd_val = run_gate_ff;
            `SCGB_DEEP_GATE_OFS: rd_val = deep_gate_ff;
            `SCGB_RUN_CFG_OFS: rd_val = run_cfg_ff;
            `SCGB_INT_STAT_OFS: rd_val = int_stat_ff;
            `SCGB_INT_EN_OFS: rd_val = int_en_ff;
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_comb begin
        nxt_prdata = prdata_ff;
        nxt_pslverr = pslverr_ff;
        if (setup) begin
            nxt_pslverr = ~known;
            nxt_prdata = rd_acc ? rd_val : 32'h0000_0000;
        end
    end

    always_comb begin
        nxt_sleep_gate = sleep_gate_ff;
        if (wr_sleep) begin
            nxt_sleep_gate = apb_req.pwdata & `SCGB_GATE_MASK;
        end
    end

    always_comb begin
        nxt_run_gate = run_gate_ff;
        if (wr_run) begin
            nxt_run_gate = apb_req.pwdata & `SCGB_GATE_MASK;
        end
    end

    always_comb begin
        nxt_deep_gate = deep_gate_ff;
        if (wr_deep) begin
            nxt_deep_gate = apb_req.pwdata & `SCGB_GATE_MASK;
        end
    end

    always_comb begin
        nxt_run_cfg = run_cfg_ff;
        if (wr_cfg) begin
            nxt_run_cfg = 32'h0000_0000;
            nxt_run_cfg[`SCGB_AUTO_GATE_BIT] =
                apb_req.pwdata[`SCGB_AUTO_GATE_BIT];
        end
    end

    always_comb begin
        nxt_int_en = int_en_ff;
        if (wr_int_en) begin
            nxt_int_en = apb_req.pwdata & `SCGB_INT_MASK;
        end
    end

    assign apb_rsp.prdata = prdata_ff;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = pslverr_ff & apb_req.psel & apb_req.penable;

    ////////////////////////////////////////////////////////////////////////
    // effective enable per unit by power mode
    always_comb begin
        case (pwr_mode)
            SCGB_RUN: sel_en = units_of(run_gate_ff);
            SCGB_SLEEP: sel_en = run_cfg_ff[`SCGB_AUTO_GATE_BIT] ?
                units_of(sleep_gate_ff) : units_of(run_gate_ff);
            SCGB_DEEP: sel_en = run_cfg_ff[`SCGB_AUTO_GATE_BIT] ?
                units_of(deep_gate_ff) : units_of(run_gate_ff);
            default: sel_en = units_of(run_gate_ff);
        endcase
        nxt_en = sel_en;
    end

    // a request to an unclocked unit faults one cycle later
    always_comb begin
        nxt_fault = periph_req.sel & (periph_req.unit < 3'd6)
            & ~en_ff[periph_req.unit];
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt: fault and gate change events, set wins over clear
    always_comb begin
        nxt_int_stat = int_stat_ff;
        if (wr_acc && apb_req.paddr == `SCGB_INT_CLR_OFS) begin
            nxt_int_stat = int_stat_ff & ~apb_req.pwdata;
        end
        if (nxt_fault) begin
            nxt_int_stat[`SCGB_EV_FAULT] = 1'b1;
        end
        if (nxt_en != en_ff) begin
            nxt_int_stat[`SCGB_EV_GATE_CHG] = 1'b1;
        end
        nxt_int_stat = nxt_int_stat & `SCGB_INT_MASK;
    end

    assign irq = |(int_stat_ff & int_en_ff);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (rst) begin
            sleep_gate_ff <= `SCGB_GATE_RESET;
        end else begin
            sleep_gate_ff <= nxt_sleep_gate;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            run_gate_ff <= `SCGB_GATE_RESET;
        end else begin
            run_gate_ff <= nxt_run_gate;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            deep_gate_ff <= `SCGB_GATE_RESET;
        end else begin
            deep_gate_ff <= nxt_deep_gate;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            run_cfg_ff <= 32'h0000_0000;
        end else begin
            run_cfg_ff <= nxt_run_cfg;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            int_stat_ff <= 32'h0000_0000;
        end else begin
            int_stat_ff <= nxt_int_stat;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            int_en_ff <= 32'h0000_0000;
        end else begin
            int_en_ff <= nxt_int_en;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata_ff <= 32'h0000_0000;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= nxt_pslverr;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            fault_ff <= 1'b0;
        end else begin
            fault_ff <= nxt_fault;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            en_ff <= '0;
        end else begin
            en_ff <= nxt_en;
        end
    end

    assign periph_fault = fault_ff;
    assign unit_clk_en = en_ff;

    ////////////////////////////////////////////////////////////////////////
    // unit clock gates; order gives bits 0,1,4,12,16,17
    for (genvar i = 0; i < `SCGB_NUM_UNITS; i++) begin : g_gate
        scgb_clk_gate u_gate (
            .clk_in(mclk),
            .en(en_ff[i]),
            .clk_out(unit_clk[i])
        );
    end
endmodule

// ---- src/scgb_regs.svh ----
// register offsets, field positions, reset values for sleep clock gating
`ifndef SCGB_REGS_SVH
`define SCGB_REGS_SVH
`define SCGB_SLEEP_GATE_OFS 12'h114
`define SCGB_RUN_GATE_OFS 12'h104
`define SCGB_DEEP_GATE_OFS 12'h124
`define SCGB_RUN_CFG_OFS 12'h060
`define SCGB_INT_STAT_OFS 12'h200
`define SCGB_INT_EN_OFS 12'h204
`define SCGB_INT_CLR_OFS 12'h208
`define SCGB_GATE_MASK 32'h0003_1013
`define SCGB_GATE_RESET 32'h0000_0000
`define SCGB_AUTO_GATE_BIT 27
`define SCGB_BIT_GPTM1 17
`define SCGB_BIT_GPTM0 16
`define SCGB_BIT_TWOWIRE0 12
`define SCGB_BIT_SSER0 4
`define SCGB_BIT_ASER1 1
`define SCGB_BIT_ASER0 0
`define SCGB_NUM_UNITS 6
`define SCGB_INT_MASK 32'h0000_0003
`define SCGB_EV_FAULT 0
`define SCGB_EV_GATE_CHG 1
`endif

// ---- src/scgb_pkg.sv ----
// types for the sleep clock gating block
package scgb_pkg;
    typedef enum logic [1:0] {
        SCGB_RUN,
        SCGB_SLEEP,
        SCGB_DEEP
    } scgb_mode_type;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } scgb_apb_req_type;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } scgb_apb_rsp_type;
    typedef struct packed {
        logic sel;
        logic [2:0] unit;
    } scgb_periph_req_type;
endpackage

// ---- src/scgb_clk_gate.sv ----
// glitch-free clock gate: enable latched while clock low
module scgb_clk_gate
    import scgb_pkg::*;
(
    // clock in
    input wire logic clk_in,
    // enable
    input wire logic en,
    // gated clock
    output logic clk_out
);
    logic en_lat;

    always_latch begin
        if (!clk_in) begin
            en_lat = en;
        end
    end

    assign clk_out = clk_in & en_lat;
endmodule

// ---- testbench/scgb_gate_monitor.sv ----
// assertions on the sleep clock gating ports
`include "scgb_regs.svh"
module scgb_gate_monitor
    import scgb_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // watched ports
    input wire scgb_apb_req_type apb_req,
    input wire scgb_apb_rsp_type apb_rsp,
    input wire scgb_mode_type pwr_mode,
    input wire scgb_periph_req_type periph_req,
    input wire logic periph_fault,
    input wire logic [5:0] unit_clk,
    input wire logic [5:0] unit_clk_en,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic acc, hit, off;
    assign acc = apb_req.psel && apb_req.penable;
    assign hit = apb_req.paddr inside {12'h114, 12'h104, 12'h124,
        12'h060, 12'h200, 12'h204, 12'h208};
    assign off = periph_req.sel && periph_req.unit < 3'h6
        && !unit_clk_en[periph_req.unit];
    sequence quiet_s;
        !apb_req.psel && $stable(pwr_mode);
    endsequence
    chk_pready_high: assert property (acc |-> apb_rsp.pready)
        else $error("pready low");
    chk_unmap_err: assert property (acc && !hit |-> apb_rsp.pslverr)
        else $error("no error on unmapped");
    chk_map_ok: assert property (acc && hit |-> !apb_rsp.pslverr)
        else $error("error on mapped");
    chk_resv_zero: assert property (acc && !apb_req.pwrite
        && apb_req.paddr == 12'h114
        |-> (apb_rsp.prdata & ~`SCGB_GATE_MASK) == 32'h0)
        else $error("reserved bit set");
    chk_fault_off: assert property (off |=> periph_fault)
        else $error("no fault");
    chk_fault_on: assert property (!off |=> !periph_fault)
        else $error("spurious fault");
    chk_reset_zero: assert property ($fell(rst) |-> unit_clk_en == 6'h0)
        else $error("enable after reset");
    chk_en_steady: assert property (quiet_s [*2] |=> $stable(unit_clk_en))
        else $error("enable moved");
endmodule
bind scgb_sleep_gate scgb_gate_monitor chk_u (.mclk(mclk), .rst(rst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .pwr_mode(pwr_mode),
    .periph_req(periph_req), .periph_fault(periph_fault),
    .unit_clk(unit_clk), .unit_clk_en(unit_clk_en), .irq(irq));

// ---- testbench/scgb_periph_model.sv ----
// gated peripherals: count edges of each unit clock
module scgb_periph_model
(
    // gated unit clocks
    input wire logic [5:0] unit_clk,
    // edge counts
    output int cnt [6]
);
    timeunit 1ns;
    timeprecision 1ps;
    for (genvar i = 0; i < 6; i++) begin : g_u
        always @(posedge unit_clk[i]) cnt[i] <= cnt[i] + 1;
    end
endmodule

// ---- testbench/scgb_sleep_gate_tb.sv ----
// self-checking bench for the sleep clock gating block
module scgb_sleep_gate_tb
    import scgb_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst = 1, periph_fault, irq;
    scgb_apb_req_type req = '0;
    scgb_apb_rsp_type rsp;
    scgb_mode_type mode = SCGB_RUN;
    scgb_periph_req_type preq = '0;
    logic [5:0] uclk, uen;
    logic [33:0] q [$], qe;
    logic [31:0] r = 32'hc7fb56f6;
    int cnt [6], c0 [6], bad_count = 0, cmp_count = 0, cyc = 0;
    int pos [6] = '{0, 1, 4, 12, 16, 17};
    scgb_sleep_gate dut_u (.mclk(mclk), .rst(rst), .apb_req(req),
        .apb_rsp(rsp), .pwr_mode(mode), .periph_req(preq),
        .periph_fault(periph_fault), .unit_clk(uclk), .unit_clk_en(uen),
        .irq(irq));
    scgb_periph_model far_u (.unit_clk(uclk), .cnt(cnt));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value at %0t: %h not %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [32:0] e);
        @(posedge mclk);
        q.push_back({e, w});
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        req.penable <= 1'b1;
        do @(posedge mclk); while (rsp.pready !== 1'b1);
        req <= '0;
    endtask
    task complete_run();
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial forever #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            complete_run();
        end
        if (req.psel && req.penable && rsp.pready === 1'b1) begin
            qe = q.pop_front();
            if (!qe[0]) chk(rsp.prdata, qe[33:2]);
            chk(rsp.pslverr, qe[1]);
        end
    end
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk) chk(uen, 0);
        apb(0, 12'h114, 0, 0);
        apb(1, 12'h118, 32'hffffffff, 1);
        apb(0, 12'h118, 0, 1);
        apb(1, 12'h114, 32'hffffffff, 0);
        apb(0, 12'h114, 0, {32'h0003_1013, 1'b0});
        repeat (4) begin
            r = lfsr(r);
            apb(1, 12'h114, r, 0);
            apb(0, 12'h114, 0, {r & 32'h0003_1013, 1'b0});
        end
        apb(1, 12'h104, 0, 0);
        apb(1, 12'h060, 32'h0800_0000, 0);
        @(posedge mclk) mode <= SCGB_SLEEP;
        for (int i = 0; i < 6; i++) begin
            apb(1, 12'h114, 32'h1 << pos[i], 0);
            repeat (3) @(negedge mclk);
            c0 = cnt;
            repeat (4) @(negedge mclk);
            chk(uen, 32'h1 << i);
            for (int k = 0; k < 6; k++)
                chk(cnt[k] != c0[k], k == i);
        end
        apb(1, 12'h208, 32'h3, 0);
        apb(1, 12'h204, 32'h1, 0);
        preq <= '{1'b1, 3'h5};
        @(posedge mclk) preq <= '{1'b1, 3'h2};
        @(negedge mclk) chk(periph_fault, 0);
        @(posedge mclk) preq <= '0;
        @(negedge mclk) chk(periph_fault, 1);
        repeat (2) @(negedge mclk);
        chk(irq, 1);
        apb(0, 12'h200, 0, {32'h1, 1'b0});
        apb(1, 12'h204, 0, 0);
        repeat (2) @(negedge mclk);
        chk(irq, 0);
        apb(1, 12'h208, 32'h1, 0);
        apb(0, 12'h200, 0, 0);
        apb(1, 12'h060, 0, 0);
        repeat (2) @(negedge mclk);
        chk(uen, 0);
        apb(1, 12'h060, 32'h0800_0000, 0);
        @(posedge mclk) mode <= SCGB_RUN;
        repeat (2) @(negedge mclk);
        chk(uen, 0);
        apb(1, 12'h124, 32'h1, 0);
        @(posedge mclk) mode <= SCGB_DEEP;
        repeat (2) @(negedge mclk);
        chk(uen, 6'h01);
        complete_run();
    end
endmodule
